// ### verilog/nbf_flags.sv
`include "nbf_defs.svh"
module nbf_flags (
  input wire logic clk_sys_i, // System clock, 250 MHz
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic master_reset_n_i, // Master reset pin, active low
  input wire logic byte_order_select_i, // Byte order strap
  input wire logic timing_mode_serial_in_i, // Mode strap, then serial in
  input wire logic parity_placement_select_i, // Parity placement strap
  input wire logic write_width_select_i, // Write width strap
  input wire logic read_width_select_i, // Read width strap
  input wire logic default_offset_select0_i, // Default offset select 0
  input wire logic default_offset_select1_i, // Default offset select 1
  input wire logic offset_load_enable_n_i, // Offset access, active low
  input wire logic write_en_i, // Write strobe, same clock
  input wire logic read_en_i, // Read strobe, same clock
  input wire logic serial_en_i, // Serial shift strobe, same clock
  input wire logic [17:0] write_data_in_i, // Write data
  output logic [17:0] read_data_o, // Read data
  output logic empty_or_output_valid_flag_n_o, // Empty / output ready
  output logic full_or_space_available_flag_n_o, // Full / input ready
  output logic half_full_flag_n_o, // Half-full, active low
  output logic almost_empty_flag_n_o, // Almost-empty, active low
  output logic almost_full_flag_n_o, // Almost-full, active low
  output nbf_pkg::nbf_cfg_t cfg_o // Captured configuration
);
  // Pin inputs pass two flip-flops before use
  logic [10:0] pin_s1;
  logic [10:0] pin_s2;
  logic [17:0] mem [0:`NBF_DEPTH-1];
  logic [`NBF_CNT_W-2:0] wr_ptr;
  logic [`NBF_CNT_W-2:0] rd_ptr;
  logic [`NBF_CNT_W-1:0] count;
  logic [`NBF_OFS_W-1:0] empty_ofs;
  logic [`NBF_OFS_W-1:0] full_ofs;
  logic [2*`NBF_OFS_W-1:0] shift_reg;
  logic [4:0] shift_cnt;
  logic out_valid;
  logic mrs_d;
  nbf_pkg::nbf_ld_t ld_ptr;
  nbf_pkg::nbf_cfg_t cfg;

  wire mrs_n = pin_s2[0];
  wire in_mrs = ~mrs_n;
  wire mrs_release = mrs_d & mrs_n;
  wire ld_n = pin_s2[8];
  wire serial_in = pin_s2[2];
  wire [2:0] dflt_sel = {pin_s2[10], pin_s2[9], pin_s2[8]};
  wire [8*`NBF_OFS_W-1:0] ofs_tab = `NBF_OFS_TAB;
  wire [`NBF_OFS_W-1:0] dflt_ofs =
    ofs_tab[dflt_sel*`NBF_OFS_W +: `NBF_OFS_W];
  wire mem_empty = (count == '0);
  wire mem_full = (count == `NBF_CNT_W'(`NBF_DEPTH));
  wire fifo_wr = write_en_i & ld_n & ~mem_full & ~in_mrs;
  wire ofs_wr = write_en_i & ~ld_n & ~in_mrs & ~cfg.serial_program;
  wire ofs_sh = serial_en_i & ~ld_n & ~in_mrs & cfg.serial_program;
  wire fifo_rd_std = read_en_i & ld_n & ~mem_empty & ~cfg.fwft_mode;
  // Fall-through: first word falls to outputs without a read
  wire fwft_load = cfg.fwft_mode & ~mem_empty & (~out_valid | read_en_i & ld_n);
  wire fwft_drop = cfg.fwft_mode & out_valid & read_en_i & ld_n & mem_empty;
  wire fifo_pop = (fifo_rd_std | fwft_load) & ~in_mrs;
  wire [1:0] dcount = {fifo_wr, fifo_pop};
  wire [`NBF_CNT_W-1:0] next_count =
    (dcount == 2'b10) ? count + 1'b1 :
    (dcount == 2'b01) ? count - 1'b1 : count;
  // Parity placement only reshapes offset words, never FIFO data
  wire [`NBF_OFS_W-1:0] par_word = cfg.parity_placement_select ?
    {write_data_in_i[17:9], write_data_in_i[7]} :
    write_data_in_i[9:0];
  wire [`NBF_OFS_W-1:0] ofs_word = cfg.write_width_select ?
    {2'b00, write_data_in_i[7:0]} : par_word;
  // Next count keeps four flags moving on the same edge; in FWFT mode the fifth follows out_valid and fwft_load
  wire [`NBF_CNT_W-1:0] free_cnt = `NBF_CNT_W'(`NBF_DEPTH) - next_count;
  wire [17:0] rd_word = mem[rd_ptr];

  always_ff @(posedge clk_sys_i)
  begin
    // Bit order must match the pin_s2 taps used by the decode wires
    pin_s1 <= {default_offset_select1_i, default_offset_select0_i,
      offset_load_enable_n_i, read_width_select_i, write_width_select_i,
      parity_placement_select_i, byte_order_select_i, 1'b0,
      timing_mode_serial_in_i, 1'b0, master_reset_n_i};
    pin_s2 <= pin_s1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      cfg <= '0;
      mrs_d <= 1'b0;
    end
    else
    begin
      mrs_d <= in_mrs;
      if (mrs_release)
      begin
        cfg.byte_order_select <= pin_s2[4];
        cfg.fwft_mode <= serial_in;
        cfg.parity_placement_select <= pin_s2[5];
        cfg.write_width_select <= pin_s2[6];
        cfg.read_width_select <= pin_s2[7];
        cfg.serial_program <= ld_n;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (fifo_wr)
      mem[wr_ptr] <= cfg.write_width_select ?
        {9'h000, write_data_in_i[8:0]} : write_data_in_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || in_mrs)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      read_data_o <= '0;
      empty_ofs <= `NBF_OFS_DFLT;
      full_ofs <= `NBF_OFS_DFLT;
      shift_reg <= '0;
      shift_cnt <= '0;
      ld_ptr <= nbf_pkg::NBF_LD_EMPTY_LO;
    end
    else
    begin
      if (mrs_d)
      begin
        empty_ofs <= dflt_ofs;
        full_ofs <= dflt_ofs;
      end
      if (fifo_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (fifo_pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
        read_data_o <= rd_word;
      end
      else if (read_en_i && !ld_n)
        read_data_o <= {8'h00, ld_ptr[1] ? full_ofs : empty_ofs};
      count <= next_count;
      if (fwft_load)
        out_valid <= 1'b1;
      else if (fwft_drop)
        out_valid <= 1'b0;
      if (ofs_wr)
      begin
        if (ld_ptr[1])
          full_ofs <= ofs_word;
        else
          empty_ofs <= ofs_word;
        ld_ptr <= ld_ptr[1] ? nbf_pkg::NBF_LD_EMPTY_LO :
          nbf_pkg::NBF_LD_FULL_LO;
      end
      if (ofs_sh)
      begin
        shift_reg <= {shift_reg[2*`NBF_OFS_W-2:0], serial_in};
        shift_cnt <= shift_cnt + 1'b1;
        if (shift_cnt == 5'(2*`NBF_OFS_W-1))
        begin
          empty_ofs <= shift_reg[2*`NBF_OFS_W-2:`NBF_OFS_W-1];
          full_ofs <= {shift_reg[`NBF_OFS_W-2:0], serial_in};
          shift_cnt <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      empty_or_output_valid_flag_n_o <= 1'b0;
      full_or_space_available_flag_n_o <= 1'b1;
      half_full_flag_n_o <= 1'b1;
      almost_empty_flag_n_o <= 1'b0;
      almost_full_flag_n_o <= 1'b1;
      cfg_o <= '0;
    end
    else
    begin
      cfg_o <= cfg;
      if (cfg.fwft_mode)
      begin
        // Low means output ready / input ready
        empty_or_output_valid_flag_n_o <= ~(out_valid | fwft_load);
        full_or_space_available_flag_n_o <= (next_count ==
          `NBF_CNT_W'(`NBF_DEPTH));
      end
      else
      begin
        empty_or_output_valid_flag_n_o <= (next_count != '0);
        full_or_space_available_flag_n_o <= (next_count !=
          `NBF_CNT_W'(`NBF_DEPTH));
      end
      half_full_flag_n_o <= ~(next_count > `NBF_HALF);
      almost_empty_flag_n_o <= (next_count >= {1'b0, empty_ofs});
      almost_full_flag_n_o <= (free_cnt > {1'b0, full_ofs});
    end
  end
endmodule

// ### verilog/nbf_defs.svh
`ifndef NBF_DEFS_SVH
`define NBF_DEFS_SVH
`define NBF_DEPTH 1024
`define NBF_CNT_W 11
`define NBF_OFS_W 10
`define NBF_DATA_W 18
`define NBF_HALF 11'h200
`define NBF_OFS_DFLT 10'h07f
`define NBF_OFS_TAB {10'h3ff, 10'h1ff, 10'h0ff, 10'h07f, \
  10'h03f, 10'h01f, 10'h00f, 10'h007}
`endif

// ### verilog/nbf_pkg.sv
package nbf_pkg;
  typedef struct packed {
    logic byte_order_select;
    logic fwft_mode;
    logic parity_placement_select;
    logic write_width_select;
    logic read_width_select;
    logic serial_program;
  } nbf_cfg_t;
  typedef enum logic [1:0] {
    NBF_LD_EMPTY_LO,
    NBF_LD_EMPTY_HI,
    NBF_LD_FULL_LO,
    NBF_LD_FULL_HI
  } nbf_ld_t;
endpackage

// ### bench/nbf_flags_sva.sv
module nbf_flags_sva (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_n_i, // Sync reset
  input wire logic master_reset_n_i, // Master reset
  input wire logic write_en_i, // Write strobe
  input wire logic read_en_i, // Read strobe
  input wire logic empty_or_output_valid_flag_n_o, // Empty / ready
  input wire logic full_or_space_available_flag_n_o, // Full / space
  input wire logic half_full_flag_n_o, // Half-full
  input wire logic almost_empty_flag_n_o, // Almost-empty
  input wire logic almost_full_flag_n_o, // Almost-full
  input wire nbf_pkg::nbf_cfg_t cfg_o // Configuration
);
  wire ef = empty_or_output_valid_flag_n_o;
  wire ff = full_or_space_available_flag_n_o;
  wire std_m = !cfg_o.fwft_mode;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // Mode and flags may move while the strap capture is still in flight
  sequence q8;
    master_reset_n_i [*8];
  endsequence
  a_empty_write: assert property
    (q8 ##0 std_m && !ef && write_en_i |=> ef) else $error("empty kept");
  a_empty_hold: assert property
    (q8 ##0 std_m && !ef && !write_en_i |=> !ef) else $error("empty lost");
  a_full_hold: assert property
    (q8 ##0 std_m && !ff && !read_en_i |=> !ff) else $error("full lost");
  a_full_write: assert property
    (q8 ##0 std_m && $fell(ff) |-> $past(write_en_i)) else $error("full");
  a_hf_cause: assert property
    ($fell(half_full_flag_n_o) |-> $past(write_en_i)) else $error("half");
  a_pae_cause: assert property
    ($rose(almost_empty_flag_n_o) |-> $past(write_en_i)) else $error("ae");
  a_paf_cause: assert property
    ($fell(almost_full_flag_n_o) |-> $past(write_en_i)) else $error("af");
  a_cfg_held: assert property
    (q8 |-> $stable(cfg_o)) else $error("config moved");
endmodule
bind nbf_flags nbf_flags_sva i_sva (.*);

// ### bench/nbf_ctrl_model.sv
module nbf_ctrl_model (
  input wire logic go_i, // Write request
  input wire logic narrow_i, // 9-bit write port
  input wire logic [17:0] data_i, // Word to send
  output logic write_en_o, // Write strobe
  output logic [17:0] data_o // Write bus
);
  assign write_en_o = go_i;
  // Unused upper lanes held low for the narrow port
  assign data_o = narrow_i ? {9'h000, data_i[8:0]} : data_i;
endmodule

// ### bench/narrow_bus_fifo_config_flags_tb_top.sv
module narrow_bus_fifo_config_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  bad_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
  logic clk_sys_i, rst_n_i, mr_n, ld_n, go, ren, we;
  logic [6:0] st;
  logic [17:0] wd, dq, rq, d, m[$];
  logic [4:0] fl, ex;
  nbf_pkg::nbf_cfg_t cfg;
  int bad_count, tests_run;
  nbf_ctrl_model i_ctrl (.go_i(go), .narrow_i(st[3]), .data_i(wd),
    .write_en_o(we), .data_o(dq));
  nbf_flags i_dut (.clk_sys_i, .rst_n_i, .master_reset_n_i(mr_n),
    .byte_order_select_i(st[6]), .timing_mode_serial_in_i(st[5]),
    .parity_placement_select_i(st[4]), .write_width_select_i(st[3]),
    .read_width_select_i(st[2]), .default_offset_select0_i(st[1]),
    .default_offset_select1_i(st[0]), .offset_load_enable_n_i(ld_n),
    .write_en_i(we), .read_en_i(ren), .serial_en_i(1'b0),
    .write_data_in_i(dq), .read_data_o(rq),
    .empty_or_output_valid_flag_n_o(fl[4]),
    .full_or_space_available_flag_n_o(fl[0]), .half_full_flag_n_o(fl[2]),
    .almost_empty_flag_n_o(fl[3]), .almost_full_flag_n_o(fl[1]),
    .cfg_o(cfg));
  initial
  begin
    clk_sys_i = 0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic mreset(logic [6:0] v);
    mr_n = 0;
    st = v;
    tick(4);
    mr_n = 1;
    tick(6);
    `CHK("cfg", v[6:2], cfg[5:1])
  endtask
  // Writes are spaced so flag checks hold for either update edge
  task automatic fill(int n, logic [17:0] mask);
    for (int k = 1; k <= n; k++)
    begin
      wd = 18'($urandom);
      m.push_back(wd & mask);
      go = 1;
      tick(1);
      go = 0;
      tick(1);
      ex = {1'b1, k >= 15, k <= 512, 1024 - k > 15, k < 1024};
      `CHK("flags", ex, fl)
    end
  endtask
  task automatic drain(int n);
    repeat (n)
    begin
      ren = 1;
      tick(1);
      ren = 0;
      tick(1);
    end
  endtask
  initial
  forever
  begin
    @(posedge clk_sys_i iff (ren && m.size() > 0));
    @(posedge clk_sys_i);
    #2;
    d = m.pop_front();
    `CHK("rdata", d, rq)
  end
  initial
  begin
    #40000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    {rst_n_i, mr_n, go, ren, st, wd} = '0;
    ld_n = 1;
    void'($urandom(7073));
    tick(6);
    rst_n_i = 1;
    repeat (3) mreset(7'($urandom));
    $display("test config done");
    mreset(7'h08);
    fill(20, 18'h001ff);
    drain(21);
    `CHK("empty", 5'h07, fl)
    $display("test narrow done");
    mreset(7'h00);
    fill(1024, 18'h3ffff);
    go = 1;
    tick(1);
    go = 0;
    tick(1);
    `CHK("full", 5'h18, fl)
    drain(1024);
    `CHK("drained", 5'h07, fl)
    $display("test wide done");
    mreset(7'h30);
    `CHK("idle", 5'h16, fl)
    wd = 18'h2a5c3;
    go = 1;
    tick(1);
    go = 0;
    for (int i = 0; i < 8 && fl[4]; i++)
      tick(1);
    `CHK("fwft", {1'b0, 18'h2a5c3}, {fl[4], rq})
    $display("test fwft done");
    report_and_stop();
  end
endmodule
